// *** logic/rtss_pkg.sv ***
/*
 * Constants, types and timing figures for the reset timer and load switch
 * sequencer. Assumes a single 25 MHz system clock.
 */
package rtss_pkg;

    // ------------------------------------------------------------------
    // Clock rate
    // ------------------------------------------------------------------
    localparam int unsigned CLK_KHZ = 32'h0000_61A8; // 25000 kHz
    localparam int unsigned CLK_MHZ = 32'h0000_0019; // 25 MHz

    // ------------------------------------------------------------------
    // Times in their own units
    // ------------------------------------------------------------------
    localparam int unsigned TURN_ON_DELAY_MS  = 32'h0000_08FC; // 2300 ms
    localparam int unsigned RESET_HOLD_MS     = 32'h0000_1D4C; // 7500 ms
    localparam int unsigned RECOVERY_PULSE_MS = 32'h0000_0190; // 400 ms
    localparam int unsigned TURN_OFF_WAIT_MS  = 32'h0000_1C84; // 7300 ms
    localparam int unsigned WAKE_ON_US        = 32'h0000_1130; // 4400 us
    localparam int unsigned ZERO_ON_US        = 32'h0000_07D0; // 2000 us
    localparam int unsigned ZERO_RESET_US     = 32'h0000_01F4; // 500 us
    localparam int unsigned ZERO_OFF_US       = 32'h0000_0258; // 600 us
    localparam int unsigned OFF_QUALIFY_US    = 32'h0000_03E8; // 1000 us
    localparam int unsigned TRIM_SENSE_US     = 32'h0000_07D0; // 2000 us

    // ------------------------------------------------------------------
    // Times in clock cycles
    // ------------------------------------------------------------------
    localparam int unsigned TURN_ON_CYC  = TURN_ON_DELAY_MS * CLK_KHZ;
    localparam int unsigned RESET_CYC    = RESET_HOLD_MS * CLK_KHZ;
    localparam int unsigned RECOVERY_CYC = RECOVERY_PULSE_MS * CLK_KHZ;
    localparam int unsigned TURN_OFF_CYC = TURN_OFF_WAIT_MS * CLK_KHZ;
    localparam int unsigned WAKE_ON_CYC  = WAKE_ON_US * CLK_MHZ;
    localparam int unsigned ZERO_ON_CYC  = ZERO_ON_US * CLK_MHZ;
    localparam int unsigned ZERO_RST_CYC = ZERO_RESET_US * CLK_MHZ;
    localparam int unsigned ZERO_OFF_CYC = ZERO_OFF_US * CLK_MHZ;
    localparam int unsigned OFF_QUAL_CYC = OFF_QUALIFY_US * CLK_MHZ;
    localparam int unsigned TRIM_CYC     = TRIM_SENSE_US * CLK_MHZ;

    // ------------------------------------------------------------------
    // Reset values of the pin view after power-on
    // ------------------------------------------------------------------
    localparam logic [3:0] PIN_RESET = 4'h9; // key_n=1, wake=0, off=0, dsr=1
    localparam logic [2:0] TRIM_RESET = 3'h7; // Tied to supply, unscaled

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic power_key_n;
        logic wake_request;
        logic off_request;
        logic delay_select;
    } rtss_pins_t;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_WAKE_ON,
        ST_ON,
        ST_OFF_WAIT,
        ST_RECOVER
    } rtss_mode_t;

    typedef struct packed {
        rtss_mode_t mode;
        logic [31:0] key_cnt;
        logic [31:0] seq_cnt;
        logic [31:0] qual_cnt;
        logic [31:0] trim_cnt;
        logic        trim_en;
        logic [2:0]  trim_code;
        logic        zero_mode;
        logic        key_armed;
        logic        off_armed;
        logic        switch_on;
        rtss_pins_t  prev;
    } rtss_state_t;

    // Delay multiplier in quarters for each trim code
    function automatic logic [3:0] trim_quarters(input logic [2:0] code);
        case (code)
            3'h0:    trim_quarters = 4'h2;
            3'h1:    trim_quarters = 4'h3;
            3'h2:    trim_quarters = 4'h5;
            3'h3:    trim_quarters = 4'h6;
            3'h4:    trim_quarters = 4'h7;
            3'h5:    trim_quarters = 4'h8;
            default: trim_quarters = 4'h4;
        endcase
    endfunction : trim_quarters

endpackage : rtss_pkg

// *** logic/rtss_sync.sv ***
/*
 * Two-flop synchroniser for a bundle of pin levels with a reset value.
 * Assumes the inputs are asynchronous to CLK.
 */
`timescale 1ns/10ps
module rtss_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_reg;

    // Second flop is the only reader of the first
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_reg <= INIT;
            q        <= INIT;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end

endmodule : rtss_sync

// *** logic/rtss_sequencer.sv ***
/*
 * Timing and decision logic for a battery load switch: power key,
 * wake and off requests, forced reset with recovery pulse, trim sense.
 * Assumes pins are asynchronous and a 25 MHz SYS_CLK.
 */
`timescale 1ns/10ps
// Overview of operation
// R01 - Off, select high: key low for turn-on delay turns output on.
// R02 - Off, select low at key fall: output turns on within milliseconds.
// R03 - On, select high: key held for reset delay starts forced reset.
// R04 - On, select low at key fall: reset starts under a millisecond.
// R05 - Reset holds output off a fixed recovery pulse, then back on.
// R06 - After power-on reset inputs read idle and output is on.
// R07 - Simultaneous triggers: key beats wake, wake beats off.
// R08 - Losing trigger is dropped, never queued; requester must repeat.
// R09 - Key or wake during long turn-off wait aborts it, output stays.
// R10 - After abort, off must go low then rise again to retry.
// R11 - Reset delay scaled by trim multiplier from 0.50 to 2.00.
// R12 - Trim tied to supply gives the unscaled reset delay.
// R13 - Trim sensed only briefly after key falls, disconnected otherwise.
// R14 - Wake rising edge turns output on from off after a few ms.
// R15 - Select high: off held high a millisecond starts long turn-off.
// R16 - Select low: qualified off edge turns off in sub-millisecond.
// R17 - Key turn-on does not arm reset until key returns high.
// R18 - Key released before reset delay clears counter, no reset.
// R19 - Select level captured at key fall picks timing for that press.
module rtss_sequencer #(
    parameter int unsigned TURN_ON_CYC  = rtss_pkg::TURN_ON_CYC,
    parameter int unsigned RESET_CYC    = rtss_pkg::RESET_CYC,
    parameter int unsigned RECOVERY_CYC = rtss_pkg::RECOVERY_CYC,
    parameter int unsigned TURN_OFF_CYC = rtss_pkg::TURN_OFF_CYC,
    parameter int unsigned WAKE_ON_CYC  = rtss_pkg::WAKE_ON_CYC,
    parameter int unsigned ZERO_ON_CYC  = rtss_pkg::ZERO_ON_CYC,
    parameter int unsigned ZERO_RST_CYC = rtss_pkg::ZERO_RST_CYC,
    parameter int unsigned ZERO_OFF_CYC = rtss_pkg::ZERO_OFF_CYC,
    parameter int unsigned OFF_QUAL_CYC = rtss_pkg::OFF_QUAL_CYC,
    parameter int unsigned TRIM_CYC     = rtss_pkg::TRIM_CYC
) (
    input  wire logic       SYS_CLK,
    input  wire logic       ARST_N,
    input  wire logic       POWER_KEY_N,
    input  wire logic       WAKE_REQUEST,
    input  wire logic       OFF_REQUEST,
    input  wire logic       DELAY_SELECT,
    input  wire logic [2:0] DELAY_TRIM_INPUT,
    output logic            SWITCH_ON,
    output logic            TRIM_SENSE_EN
);

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    rtss_pkg::rtss_pins_t pins_raw;
    rtss_pkg::rtss_pins_t pins;
    logic [2:0]           trim_sync;

    assign pins_raw = '{POWER_KEY_N, WAKE_REQUEST, OFF_REQUEST, DELAY_SELECT};

    // Idle pin levels after power-on
    rtss_sync #(.WIDTH(4), .INIT(rtss_pkg::PIN_RESET)) u_pin_sync ( // R06
        .clk    (SYS_CLK),
        .arst_n (ARST_N),
        .d      (pins_raw),
        .q      (pins)
    );

    rtss_sync #(.WIDTH(3), .INIT(rtss_pkg::TRIM_RESET)) u_trim_sync (
        .clk    (SYS_CLK),
        .arst_n (ARST_N),
        .d      (DELAY_TRIM_INPUT),
        .q      (trim_sync)
    );

    // ------------------------------------------------------------------
    // State and derived events
    // ------------------------------------------------------------------
    rtss_pkg::rtss_state_t st_reg;
    rtss_pkg::rtss_state_t st_next;
    logic                  key_fall;
    logic                  wake_rise;
    logic                  off_qualified;
    logic [33:0]           scaled;
    logic [31:0]           reset_thr;

    // Edges against the previous synchronised levels
    assign key_fall  = st_reg.prev.power_key_n && !pins.power_key_n;
    assign wake_rise = !st_reg.prev.wake_request && pins.wake_request;
    assign off_qualified = st_reg.off_armed && pins.off_request &&
                           (st_reg.qual_cnt == 32'(OFF_QUAL_CYC - 1)); // R15

    // Reset delay scaled in quarters by the latched trim code
    assign scaled = 34'(RESET_CYC) *
                    34'(rtss_pkg::trim_quarters(st_reg.trim_code)); // R11 R12
    assign reset_thr = st_reg.zero_mode ? 32'(ZERO_RST_CYC)
                                        : scaled[33:2]; // R04

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        st_next      = st_reg;
        st_next.prev = pins;

        // Key timing counter, cleared whenever the key is high
        if (pins.power_key_n) begin
            st_next.key_cnt   = 32'h0000_0000; // R18
            st_next.key_armed = 1'b1; // R17
        end else if (st_reg.key_cnt != 32'hFFFF_FFFF) begin
            st_next.key_cnt = st_reg.key_cnt + 32'h0000_0001;
        end
        if (key_fall) begin
            st_next.key_cnt   = 32'h0000_0000;
            st_next.zero_mode = !pins.delay_select; // R19 R02 R04
        end

        // Trim sense window opened by every key fall
        if (key_fall) begin
            st_next.trim_en  = 1'b1; // R13
            st_next.trim_cnt = 32'h0000_0000;
        end else if (st_reg.trim_en) begin
            st_next.trim_cnt = st_reg.trim_cnt + 32'h0000_0001;
            if (st_reg.trim_cnt == 32'(TRIM_CYC - 1)) begin
                st_next.trim_en   = 1'b0; // R13
                st_next.trim_code = trim_sync;
            end
        end

        // Off request qualification: rising edge then high for a while
        if (!pins.off_request) begin
            st_next.off_armed = 1'b1; // R10
            st_next.qual_cnt  = 32'h0000_0000;
        end else if (st_reg.off_armed) begin
            st_next.qual_cnt = st_reg.qual_cnt + 32'h0000_0001;
            if (off_qualified) begin
                st_next.off_armed = 1'b0;
            end
        end

        st_next.seq_cnt = st_reg.seq_cnt + 32'h0000_0001;
        case (st_reg.mode)
            rtss_pkg::ST_OFF: begin
                // Key press wins over a simultaneous wake edge
                if (!pins.power_key_n && !key_fall &&
                    st_reg.key_cnt == 32'(st_reg.zero_mode ? ZERO_ON_CYC - 1
                                          : TURN_ON_CYC - 1)) begin
                    st_next.mode      = rtss_pkg::ST_ON; // R01 R02
                    st_next.switch_on = 1'b1;
                    st_next.key_armed = 1'b0; // R17
                end else if (wake_rise && !key_fall) begin
                    st_next.mode    = rtss_pkg::ST_WAKE_ON; // R14 R07 R08
                    st_next.seq_cnt = 32'h0000_0000;
                end
            end
            rtss_pkg::ST_WAKE_ON: begin
                if (st_reg.seq_cnt == 32'(WAKE_ON_CYC - 1)) begin
                    st_next.mode      = rtss_pkg::ST_ON; // R14
                    st_next.switch_on = 1'b1;
                end
            end
            rtss_pkg::ST_ON: begin
                if (!pins.power_key_n && !key_fall && st_reg.key_armed &&
                    st_reg.key_cnt == reset_thr - 32'h0000_0001) begin
                    st_next.mode      = rtss_pkg::ST_RECOVER; // R03 R04
                    st_next.switch_on = 1'b0;
                    st_next.seq_cnt   = 32'h0000_0000;
                end else if (off_qualified && !key_fall && !wake_rise) begin
                    st_next.mode    = rtss_pkg::ST_OFF_WAIT; // R15 R16 R07
                    st_next.seq_cnt = 32'h0000_0000;
                    st_next.zero_mode = !pins.delay_select;
                end
            end
            rtss_pkg::ST_OFF_WAIT: begin
                if (!st_reg.zero_mode && (key_fall || wake_rise)) begin
                    st_next.mode      = rtss_pkg::ST_ON; // R09
                    st_next.off_armed = 1'b0; // R10
                end else if (st_reg.seq_cnt == 32'(st_reg.zero_mode
                             ? ZERO_OFF_CYC - 1 : TURN_OFF_CYC - 1)) begin
                    st_next.mode      = rtss_pkg::ST_OFF; // R15 R16
                    st_next.switch_on = 1'b0;
                end
            end
            rtss_pkg::ST_RECOVER: begin
                if (st_reg.seq_cnt == 32'(RECOVERY_CYC - 1)) begin
                    st_next.mode      = rtss_pkg::ST_ON; // R05
                    st_next.switch_on = 1'b1;
                    st_next.key_armed = pins.power_key_n;
                end
            end
            default: begin
                st_next.mode      = rtss_pkg::ST_ON;
                st_next.switch_on = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st_reg           <= '0;
            st_reg.mode      <= rtss_pkg::ST_ON; // R06
            st_reg.switch_on <= 1'b1; // R06
            st_reg.trim_code <= rtss_pkg::TRIM_RESET;
            st_reg.key_armed <= 1'b1;
            st_reg.prev      <= rtss_pkg::PIN_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state register
    assign SWITCH_ON     = st_reg.switch_on;
    assign TRIM_SENSE_EN = st_reg.trim_en;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!ARST_N);

    sequence s_wait_active;
        st_reg.mode == rtss_pkg::ST_OFF_WAIT && !st_reg.zero_mode;
    endsequence

    sequence s_abort_trigger;
        key_fall || wake_rise;
    endsequence

    a_key_turn_on: assert property ( // R01 R02
        $rose(st_reg.switch_on) && $past(st_reg.mode) == rtss_pkg::ST_OFF
        |-> $past(st_reg.key_cnt) == 32'($past(st_reg.zero_mode)
            ? ZERO_ON_CYC - 1 : TURN_ON_CYC - 1))
        else $error("Key turn-on at wrong hold time");

    a_reset_start: assert property ( // R03 R04 R11
        $fell(st_reg.switch_on) && $past(st_reg.mode) == rtss_pkg::ST_ON
        |-> $past(st_reg.key_cnt) == $past(reset_thr) - 32'h0000_0001)
        else $error("Forced reset at wrong hold time");

    a_recovery_len: assert property ( // R05
        $past(st_reg.mode) == rtss_pkg::ST_RECOVER &&
        st_reg.mode == rtss_pkg::ST_ON
        |-> $past(st_reg.seq_cnt) == 32'(RECOVERY_CYC - 1) && SWITCH_ON)
        else $error("Recovery pulse wrong length");

    a_recover_off: assert property ( // R05
        st_reg.mode == rtss_pkg::ST_RECOVER |-> !SWITCH_ON)
        else $error("Output on during recovery");

    a_wake_delay: assert property ( // R14
        $past(st_reg.mode) == rtss_pkg::ST_WAKE_ON && SWITCH_ON &&
        !$past(SWITCH_ON)
        |-> $past(st_reg.seq_cnt) == 32'(WAKE_ON_CYC - 1))
        else $error("Wake turn-on at wrong time");

    a_wait_abort: assert property ( // R09 R07
        s_wait_active ##0 s_abort_trigger
        |=> st_reg.mode == rtss_pkg::ST_ON && SWITCH_ON && !st_reg.off_armed)
        else $error("Turn-off wait not abandoned");

    a_off_rearm: assert property ( // R10 R08
        st_reg.mode != rtss_pkg::ST_OFF_WAIT ##1
        st_reg.mode == rtss_pkg::ST_OFF_WAIT |-> $past(st_reg.off_armed))
        else $error("Turn-off started without fresh edge");

    a_unarmed_key: assert property ( // R17
        st_reg.mode == rtss_pkg::ST_ON && !st_reg.key_armed
        |=> st_reg.mode != rtss_pkg::ST_RECOVER)
        else $error("Reset from unarmed key");

    a_release_clr: assert property ( // R18
        pins.power_key_n |=> st_reg.key_cnt == 32'h0000_0000)
        else $error("Key counter not cleared on release");

    a_trim_window: assert property ( // R13
        key_fall |=> TRIM_SENSE_EN [*2])
        else $error("Trim sense not opened after key fall");

endmodule : rtss_sequencer

// *** verif/rtss_far_end.sv ***
/*
 * Far-side model: power key, system wake controller and PMIC pins.
 * Assumes one bench process calls its tasks; pins move on falling edges.
 */
`timescale 1ns/10ps
module rtss_far_end (
    input  wire logic       sys_clk,
    output logic            power_key_n,
    output logic            wake_request,
    output logic            off_request,
    output logic            delay_select,
    output logic [2:0]      delay_trim_input
);
    // -----------------------------------------------------------------
    // Idle levels and pin drive
    // -----------------------------------------------------------------
    // Idle levels as after power-on
    initial begin
        power_key_n      = 1'b1;
        wake_request     = 1'b0;
        off_request      = 1'b0;
        delay_select     = 1'b1;
        delay_trim_input = 3'h7;
    end

    // Key, wake, off and select change together just after a falling edge
    task automatic pins(input logic k, input logic w, input logic o,
                        input logic d);
        @(negedge sys_clk);
        power_key_n  = k;
        wake_request = w;
        off_request  = o;
        delay_select = d;
    endtask : pins

    // Resistor code seen by the trim sense
    task automatic trim(input logic [2:0] c);
        @(negedge sys_clk);
        delay_trim_input = c;
    endtask : trim
endmodule : rtss_far_end

// *** verif/testbench.sv ***
/*
 * Self-checking bench for the load switch sequencer, shortened counts.
 * Assumes rtss_far_end drives every input pin of the sequencer except SYS_CLK and ARST_N.
 */
`timescale 1ns/10ps
module testbench;
    localparam int T_ON = 40, T_RST = 80, T_REC = 20, T_OFF = 60;
    localparam int T_WAKE = 10, T_ZON = 5, T_ZRST = 4, T_ZOFF = 3;
    localparam int T_QUAL = 6, T_TRIM = 3;

    logic       sys_clk;
    logic       arst_n;
    logic       key_n, wake, off_rq, dsel, sw_on, trim_en;
    logic [2:0] trim_code;
    int         error_cnt = 0;
    int         checks_done = 0;
    int         n, th;

    // -----------------------------------------------------------------
    // Clock, reset, design and far side
    // -----------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    rtss_sequencer #(.TURN_ON_CYC(T_ON), .RESET_CYC(T_RST),
        .RECOVERY_CYC(T_REC), .TURN_OFF_CYC(T_OFF), .WAKE_ON_CYC(T_WAKE),
        .ZERO_ON_CYC(T_ZON), .ZERO_RST_CYC(T_ZRST), .ZERO_OFF_CYC(T_ZOFF),
        .OFF_QUAL_CYC(T_QUAL), .TRIM_CYC(T_TRIM)) dut_u (
        .SYS_CLK(sys_clk), .ARST_N(arst_n), .POWER_KEY_N(key_n),
        .WAKE_REQUEST(wake), .OFF_REQUEST(off_rq), .DELAY_SELECT(dsel),
        .DELAY_TRIM_INPUT(trim_code), .SWITCH_ON(sw_on),
        .TRIM_SENSE_EN(trim_en));

    rtss_far_end far_u (.sys_clk(sys_clk), .power_key_n(key_n),
        .wake_request(wake), .off_request(off_rq), .delay_select(dsel),
        .delay_trim_input(trim_code));

    // -----------------------------------------------------------------
    // Shared helpers
    // -----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %0d seen %0d", what, exp, seen);
        end
    endtask : check

    // Cycles until the switch reaches v; trim sense cycles on the way
    task automatic wait_sw(input logic v, input int lim);
        n = 0;
        th = 0;
        while (sw_on !== v && n < lim) begin
            @(negedge sys_clk);
            n++;
            if (trim_en === 1'b1) th++;
        end
    endtask : wait_sw

    // Delay must lie within sync latency of its nominal count
    task automatic near(input string what, input int e);
        check(what, 32'(n >= e && n <= e + 5), 32'h1);
    endtask : near

    // Switch must keep level v for the whole span
    task automatic hold_sw(input logic v, input int cyc);
        int good;
        good = 0;
        repeat (cyc) begin
            @(negedge sys_clk);
            if (sw_on === v) good++;
        end
        check("switch steady", good, cyc);
    endtask : hold_sw

    // -----------------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------------
    // Each trim code scales the long reset delay; pulse is fixed
    task automatic s_reset_trim();
        int q [8] = '{2, 3, 5, 6, 7, 8, 4, 4};
        for (int c = 0; c < 8; c++) begin
            far_u.trim(3'(c));
            far_u.pins(1'b0, 1'b0, 1'b0, 1'b1);
            wait_sw(1'b0, 400);
            near("reset delay", T_RST * q[c] / 4);
            check("trim window", th, T_TRIM);
            wait_sw(1'b1, 100);
            check("recovery", n, T_REC);
            hold_sw(1'b1, 100);
            far_u.pins(1'b1, 1'b0, 1'b0, 1'b1);
        end
    endtask : s_reset_trim

    // Key let go before the delay: no reset pulse
    task automatic s_release_early();
        far_u.pins(1'b0, 1'b0, 1'b0, 1'b1);
        repeat (T_RST / 2) @(negedge sys_clk);
        far_u.pins(1'b1, 1'b0, 1'b0, 1'b1);
        hold_sw(1'b1, T_RST + 40);
    endtask : s_release_early

    // Select low before the key falls: immediate reset, same pulse
    task automatic s_zero_reset();
        far_u.pins(1'b1, 1'b0, 1'b0, 1'b0);
        far_u.pins(1'b0, 1'b0, 1'b0, 1'b0);
        wait_sw(1'b0, 50);
        near("zero reset", T_ZRST);
        wait_sw(1'b1, 100);
        check("zero recovery", n, T_REC);
        far_u.pins(1'b1, 1'b0, 1'b0, 1'b1);
    endtask : s_zero_reset

    // Qualified off edge, long wait or zero-second wait
    task automatic s_off(input logic d);
        far_u.pins(1'b1, 1'b0, 1'b1, d);
        wait_sw(1'b0, 200);
        near("off delay", T_QUAL + (d ? T_OFF : T_ZOFF));
        far_u.pins(1'b1, 1'b0, 1'b0, 1'b1);
    endtask : s_off

    // Key turn-on, long or zero; held key must not reset
    task automatic s_key_on(input logic d);
        far_u.pins(1'b1, 1'b0, 1'b0, d);
        far_u.pins(1'b0, 1'b0, 1'b0, d);
        wait_sw(1'b1, 100);
        near("turn on", d ? T_ON : T_ZON);
        hold_sw(1'b1, T_RST + 40);
        far_u.pins(1'b1, 1'b0, 1'b0, 1'b1);
    endtask : s_key_on

    // Wake or key during long wait aborts; off needs a new edge
    task automatic s_abort(input logic by_key);
        far_u.pins(1'b1, 1'b0, 1'b1, 1'b1);
        repeat (T_QUAL + 20) @(negedge sys_clk);
        far_u.pins(!by_key, !by_key, 1'b1, 1'b1);
        far_u.pins(1'b1, 1'b0, 1'b1, 1'b1);
        hold_sw(1'b1, T_OFF + 30);
        far_u.pins(1'b1, 1'b0, 1'b0, 1'b1);
        s_off(1'b1);
    endtask : s_abort

    // Key and wake together from off: wake dropped until re-edged
    task automatic s_conflict();
        far_u.pins(1'b0, 1'b1, 1'b0, 1'b1);
        far_u.pins(1'b1, 1'b1, 1'b0, 1'b1);
        hold_sw(1'b0, T_WAKE + 20);
        far_u.pins(1'b1, 1'b0, 1'b0, 1'b1);
        far_u.pins(1'b1, 1'b1, 1'b0, 1'b1);
        wait_sw(1'b1, 50);
        near("wake on", T_WAKE);
        far_u.pins(1'b1, 1'b0, 1'b0, 1'b1);
    endtask : s_conflict

    // -----------------------------------------------------------------
    // Verdict, watchdog and main sequence
    // -----------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report

    // Whole run needs about 3000 cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        final_report();
    end

    initial begin
        arst_n = 1'b0;
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        arst_n = 1'b1;
        @(negedge sys_clk);
        check("switch after reset", sw_on, 32'h1);
        check("trim after reset", trim_en, 32'h0);
        hold_sw(1'b1, 20);
        s_reset_trim();
        s_release_early();
        s_zero_reset();
        s_off(1'b1);
        s_key_on(1'b1);
        s_abort(1'b0);
        s_key_on(1'b0);
        s_abort(1'b1);
        s_key_on(1'b1);
        s_off(1'b0);
        s_conflict();
        final_report();
    end
endmodule : testbench
